// ---- dapr_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
// Operation
// - activate after read_with_self_precharge waits rtp+rp
// - reactivate needs trp and trc met
// - write_ap reactivate after wr+rp, trc
// - refresh: cs ras cas low
// - all banks idle trp before refresh
// - wait trfc after refresh
// - post up to eight, gap nine trefi
// - self refresh with odt off, idle
// - hold cke low tcke in self refresh
// - clock may stop after entry
// - exit waits txsnr, txsrd for reads
// - nop during exit, refresh before reentry
// - no power-down during read, write, mrs
// - hold cke low, odt valid tcke
// - exit with nop, wait txp
// - async cke drop needs full reinit
// - freq change in precharge power-down only
module dapr_ctrl
  import dapr_pkg::*;
#(
  parameter int BL = 4,
  parameter int AL = 0,
  parameter int REFI_CK = T_REFI_CK,
  parameter int XSRD_CK = T_XSRD_CK
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire dapr_user_t req_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic wake_i,
  input wire logic clk_stable_i,
  output dapr_pins_t pins_o,
  output logic clk_stop_ok_o,
  output logic freq_chg_ok_o,
  output logic reinit_req_o,
  output logic busy_o
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_REF_WAIT = 4'h1,
    ST_SR_ENTER = 4'h2,
    ST_SR = 4'h3,
    ST_SR_EXIT = 4'h4,
    ST_PD = 4'h5,
    ST_PD_EXIT = 4'h6,
    ST_ABORT = 4'h7,
    ST_DLL_RST = 4'h8,
    ST_ODT_OFF = 4'h9
  } dapr_st_t;

  localparam int BL8_EXTRA = (BL == 8) ? 2 : 0;
  // precharge sits at al+bl/2 unless trtp pushes it further out
  localparam int RDAP_ACT_CK = (BL / 2 + T_RP_CK > BL8_EXTRA + T_RTPRP_CK) ?
      AL + BL / 2 + T_RP_CK : AL + BL8_EXTRA + T_RTPRP_CK;
  localparam int WRAP_ACT_CK = AL + BL - 1 + BL / 2 + T_WR_CK + T_RP_CK;
  localparam int RD_BUSY_CK = AL + BL / 2;
  localparam int WR_BUSY_CK = AL + BL - 1 + BL / 2;
  localparam logic [CNT_W-1:0] REFI_W = CNT_W'(REFI_CK);

  dapr_st_t st_r, st_nxt;
  dapr_pins_t pins_r, pins_nxt;
  logic [CNT_W-1:0] refi_cnt_r, refi_cnt_nxt;
  logic [3:0] owed_r, owed_nxt;
  logic [BANKS-1:0] open_r, open_nxt;
  logic extra_ref_r, extra_ref_nxt;
  logic pd_idle_r, pd_idle_nxt;
  logic freq_r, freq_nxt;
  logic [CNT_W-1:0] wait_val;
  logic wait_load, wait_done;
  logic [CNT_W-1:0] io_val;
  logic io_load, io_done;
  logic [BANKS-1:0] act_load;
  logic [CNT_W-1:0] act_val [BANKS];
  logic [BANKS-1:0] act_done;
  logic [BANKS-1:0] rc_done;

  // shared wait for state timings
  dapr_timer u_wait (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .load_i(wait_load),
    .val_i(wait_val),
    .done_o(wait_done)
  );

  // read or write burst in flight blocks power-down
  dapr_timer u_io (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .load_i(io_load),
    .val_i(io_val),
    .done_o(io_done)
  );

  // per bank: earliest reactivation and row cycle
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    dapr_timer u_act (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .load_i(act_load[b]),
      .val_i(act_val[b]),
      .done_o(act_done[b])
    );
    dapr_timer u_rc (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .load_i(act_load[b] && st_r == ST_IDLE && req_i.kind == REQ_ACT),
      .val_i(CNT_W'(T_RC_CK - 1)),
      .done_o(rc_done[b])
    );
  end

  logic bank_ready;
  logic do_ref;
  logic all_idle;
  assign all_idle = (open_r == '0) && (&act_done);
  assign bank_ready = act_done[req_i.bank] && rc_done[req_i.bank];
  // refresh once owed and every bank precharged
  assign do_ref = (owed_r != 4'h0) && all_idle && wait_done;

  // main sequencing
  always_comb begin
    st_nxt = st_r;
    pins_nxt = pins_r;
    pins_nxt.cmd = CMD_NOP;
    pins_nxt.ba = 2'h0;
    pins_nxt.a = 13'h0000;
    open_nxt = open_r;
    extra_ref_nxt = extra_ref_r;
    pd_idle_nxt = pd_idle_r;
    freq_nxt = freq_r;
    owed_nxt = owed_r;
    wait_load = 1'b0;
    wait_val = '0;
    io_load = 1'b0;
    io_val = '0;
    act_load = '0;
    for (int i = 0; i < BANKS; i++) begin
      act_val[i] = '0;
    end
    req_ready_o = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        pins_nxt.cke = 1'b1;
        pins_nxt.odt = 1'b1; // termination on in normal operation
        if (req_valid_i && req_i.kind == REQ_ABORT) begin
          pins_nxt.cke = 1'b0;
          pins_nxt.odt = 1'b0;
          req_ready_o = 1'b1;
          wait_load = 1'b1;
          wait_val = CNT_W'(T_DELAY_CK);
          st_nxt = ST_ABORT;
        end else if (do_ref) begin
          // issued only with all banks idle past trp
          pins_nxt.cmd = CMD_REF;
          owed_nxt = owed_r - 4'h1;
          extra_ref_nxt = 1'b0;
          wait_load = 1'b1;
          wait_val = CNT_W'(T_RFC_CK - 1);
          st_nxt = ST_REF_WAIT;
        end else if (req_valid_i && wait_done && owed_r < 4'(MAX_POSTED)) begin
          unique case (req_i.kind)
            REQ_ACT: begin
              if (bank_ready && !open_r[req_i.bank]) begin
                pins_nxt.cmd = CMD_ACT;
                pins_nxt.ba = req_i.bank;
                pins_nxt.a = req_i.addr;
                open_nxt[req_i.bank] = 1'b1;
                act_load[req_i.bank] = 1'b1;
                act_val[req_i.bank] = CNT_W'(T_RAS_CK - 1);
                req_ready_o = 1'b1;
              end
            end
            REQ_RD_AP, REQ_WR_AP: begin
              if (open_r[req_i.bank] && act_done[req_i.bank]) begin
                pins_nxt.cmd = (req_i.kind == REQ_RD_AP) ? CMD_RD : CMD_WR;
                pins_nxt.ba = req_i.bank;
                pins_nxt.a = req_i.addr | (13'h0001 << A10_BIT);
                open_nxt[req_i.bank] = 1'b0;
                act_load[req_i.bank] = 1'b1;
                act_val[req_i.bank] = (req_i.kind == REQ_RD_AP) ?
                    CNT_W'(RDAP_ACT_CK - 1) : CNT_W'(WRAP_ACT_CK - 1);
                io_load = 1'b1;
                io_val = (req_i.kind == REQ_RD_AP) ?
                    CNT_W'(RD_BUSY_CK) : CNT_W'(WR_BUSY_CK);
                req_ready_o = 1'b1;
              end
            end
            REQ_SELF_REF: begin
              // odt off first, all banks idle
              if (all_idle && io_done && !extra_ref_r) begin
                pins_nxt.odt = 1'b0;
                wait_load = 1'b1;
                wait_val = CNT_W'(T_CKE_CK);
                st_nxt = ST_ODT_OFF;
                req_ready_o = 1'b1;
              end
            end
            REQ_PDOWN, REQ_FREQ_CHG: begin
              // never while a burst is in progress
              // frequency change needs all banks idle
              if (io_done && (req_i.kind == REQ_PDOWN || all_idle)) begin
                pins_nxt.cke = 1'b0;
                pd_idle_nxt = all_idle;
                freq_nxt = (req_i.kind == REQ_FREQ_CHG);
                if (req_i.kind == REQ_FREQ_CHG) begin
                  pins_nxt.odt = 1'b0;
                end
                wait_load = 1'b1;
                wait_val = (req_i.kind == REQ_FREQ_CHG) ?
                    CNT_W'(T_FCHG_CK) : CNT_W'(T_CKE_CK);
                st_nxt = ST_PD;
                req_ready_o = 1'b1;
              end
            end
            default: begin
              req_ready_o = 1'b1;
            end
          endcase
        end
      end
      ST_REF_WAIT: begin
        if (wait_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_ODT_OFF: begin
        if (wait_done) begin
          // self refresh entry: cke low with refresh code
          pins_nxt.cmd = CMD_REF;
          pins_nxt.cke = 1'b0;
          wait_load = 1'b1;
          wait_val = CNT_W'(T_CKE_CK);
          st_nxt = ST_SR_ENTER;
        end
      end
      ST_SR_ENTER: begin
        if (wait_done) begin
          st_nxt = ST_SR;
        end
      end
      ST_SR: begin
        // raise cke only on a stable clock
        if (wake_i && clk_stable_i) begin
          pins_nxt.cke = 1'b1;
          wait_load = 1'b1;
          // one wait covers both; a short read delay must not cut txsnr
          wait_val = CNT_W'((XSRD_CK > T_XSNR_CK) ? XSRD_CK : T_XSNR_CK);
          extra_ref_nxt = 1'b1;
          owed_nxt = (owed_r == 4'h0) ? 4'h1 : owed_r;
          st_nxt = ST_SR_EXIT;
        end
      end
      ST_SR_EXIT: begin
        // wait the longer of the read and non-read exit delays, odt off
        if (wait_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_PD: begin
        // cke low, odt held for tcke at least
        if (wait_done && wake_i && clk_stable_i) begin
          // exit with nop and cke high
          pins_nxt.cke = 1'b1;
          wait_load = 1'b1;
          wait_val = CNT_W'(T_XP_CK);
          st_nxt = ST_PD_EXIT;
        end
      end
      ST_PD_EXIT: begin
        if (wait_done) begin
          if (freq_r) begin
            // dll reset via mode register set
            pins_nxt.cmd = CMD_MRS;
            pins_nxt.a = 13'h0100;
            freq_nxt = 1'b0;
            st_nxt = ST_DLL_RST;
            wait_load = 1'b1;
            wait_val = CNT_W'(XSRD_CK);
          end else begin
            st_nxt = ST_IDLE;
          end
        end
      end
      ST_DLL_RST: begin
        // odt kept off until relock
        if (wait_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_ABORT: begin
        // contents lost; hold until stable clock
        if (wait_done && clk_stable_i) begin
          open_nxt = '0;
          pins_nxt.cke = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // refresh interval ticks; owed debt saturates below
  always_comb begin
    refi_cnt_nxt = refi_cnt_r - 1'b1;
    if (refi_cnt_r == '0) begin
      refi_cnt_nxt = REFI_W - 1'b1;
    end
  end

  logic [3:0] owed_fin;
  // a tick in the same cycle as a refresh still counts
  assign owed_fin = owed_nxt + ((refi_cnt_r == '0 && st_r != ST_SR) ? 4'h1 : 4'h0);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= ST_IDLE;
      pins_r <= '{CMD_NOP, 1'b0, 1'b0, 2'h0, 13'h0000};
      refi_cnt_r <= REFI_W - 1'b1;
      owed_r <= 4'h0;
      open_r <= '0;
      extra_ref_r <= 1'b0;
      pd_idle_r <= 1'b0;
      freq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pins_r <= pins_nxt;
      refi_cnt_r <= refi_cnt_nxt;
      owed_r <= (owed_fin > 4'(MAX_POSTED + 1)) ? 4'(MAX_POSTED + 1) : owed_fin;
      open_r <= open_nxt;
      extra_ref_r <= extra_ref_nxt;
      pd_idle_r <= pd_idle_nxt;
      freq_r <= freq_nxt;
    end
  end

  assign pins_o = pins_r;
  // clock may stop four cycles after entry registers, once the tcke hold ends
  assign clk_stop_ok_o = (st_r == ST_SR) || (st_r == ST_ABORT && wait_done);
  assign freq_chg_ok_o = (st_r == ST_PD) && freq_r && pd_idle_r && wait_done;
  assign reinit_req_o = (st_r == ST_ABORT) && wait_done && clk_stable_i;
  assign busy_o = (st_r != ST_IDLE) || !io_done;
endmodule
`default_nettype wire

// ---- dapr_pkg.sv ----
package dapr_pkg;
  // controller clock period and timing figures
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RP_NS = 15;
  localparam int T_RC_NS = 60;
  localparam int T_RAS_NS = 45;
  localparam int T_RTP_NS = 8;
  localparam int T_WR_NS = 15;
  localparam int T_RFC_NS = 128;
  localparam int T_REFI_NS = 7800;
  localparam int T_XSNR_NS = 138;
  localparam int T_CKE_CK = 3;
  localparam int T_XP_CK = 2;
  localparam int T_XSRD_CK = 200;
  localparam int T_FCHG_CK = 2;
  localparam int T_DELAY_NS = 20;
  localparam int MAX_POSTED = 8;
  localparam int REFI_SPAN = 9;
  // least times round up
  localparam int T_RP_CK = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RC_CK = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RAS_CK = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RTP_CK = (T_RTP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WR_CK = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RFC_CK = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_XSNR_CK = (T_XSNR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_DELAY_CK = (T_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RTPRP_CK = (T_RTP_NS + T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // average interval, a longest time, rounds down
  localparam int T_REFI_CK = T_REFI_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int A10_BIT = 10;
  localparam int BANKS = 4;

  // command pins: cs_n, ras_n, cas_n, we_n
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dapr_cmd_t;
  localparam dapr_cmd_t CMD_NOP = '{1'b0, 1'b1, 1'b1, 1'b1};
  localparam dapr_cmd_t CMD_ACT = '{1'b0, 1'b0, 1'b1, 1'b1};
  localparam dapr_cmd_t CMD_RD = '{1'b0, 1'b1, 1'b0, 1'b1};
  localparam dapr_cmd_t CMD_WR = '{1'b0, 1'b1, 1'b0, 1'b0};
  localparam dapr_cmd_t CMD_REF = '{1'b0, 1'b0, 1'b0, 1'b1};
  localparam dapr_cmd_t CMD_MRS = '{1'b0, 1'b0, 1'b0, 1'b0};

  // user request kinds
  typedef enum logic [3:0] {
    REQ_NONE = 4'h0,
    REQ_ACT = 4'h1,
    REQ_RD_AP = 4'h2,
    REQ_WR_AP = 4'h3,
    REQ_SELF_REF = 4'h4,
    REQ_PDOWN = 4'h5,
    REQ_FREQ_CHG = 4'h6,
    REQ_ABORT = 4'h7
  } dapr_req_t;

  typedef struct packed {
    dapr_req_t kind;
    logic [1:0] bank;
    logic [12:0] addr;
  } dapr_user_t;

  // pin group towards the memory
  typedef struct packed {
    dapr_cmd_t cmd;
    logic cke;
    logic odt;
    logic [1:0] ba;
    logic [12:0] a;
  } dapr_pins_t;
endpackage

// ---- dapr_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
// loadable down counter; done while zero
module dapr_timer
  import dapr_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [W-1:0] val_i,
  output logic done_o
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // load wins over counting so a restart is never lost
  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = val_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = (cnt_r == '0);
endmodule
`default_nettype wire

// ---- dapr_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
// pin timing watcher for the controller, attached by bind
module dapr_monitor
  import dapr_pkg::*;
#(
  parameter int BL = 4,
  parameter int AL = 0,
  parameter int REFI_CK = T_REFI_CK,
  parameter int XSRD_CK = T_XSRD_CK
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire dapr_user_t req_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire dapr_pins_t pins_o,
  input wire logic freq_chg_ok_o
);
  localparam int RD_GAP = (BL / 2 + T_RP_CK > T_RTPRP_CK + ((BL == 8) ? 2 : 0)) ?
      AL + BL / 2 + T_RP_CK : AL + T_RTPRP_CK + ((BL == 8) ? 2 : 0);
  localparam int WR_GAP = AL + BL / 2 + T_WR_CK + T_RP_CK;
  logic act, colap, nop, ref_seen_r;
  logic [BANKS-1:0] ap_wr_r;
  int act_cnt_r [BANKS];
  int ap_cnt_r [BANKS];
  int ref_cnt_r, live_r;
  assign act = (pins_o.cmd == CMD_ACT);
  assign colap = (pins_o.cmd == CMD_RD || pins_o.cmd == CMD_WR) && pins_o.a[A10_BIT];
  assign nop = pins_o.cmd.cs_n || (pins_o.cmd == CMD_NOP);
  // cycles since each bank event; saturate so they never wrap
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int b = 0; b < BANKS; b++) begin
        act_cnt_r[b] <= 1000;
        ap_cnt_r[b] <= 1000;
      end
      ap_wr_r <= '0;
      ref_cnt_r <= 0;
      live_r <= 0;
      ref_seen_r <= 1'b0;
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        if (act && pins_o.ba == b) act_cnt_r[b] <= 1;
        else if (act_cnt_r[b] < 1000) act_cnt_r[b] <= act_cnt_r[b] + 1;
        if (colap && pins_o.ba == b) begin
          ap_cnt_r[b] <= 1;
          ap_wr_r[b] <= ~pins_o.cmd.we_n;
        end else if (ap_cnt_r[b] < 1000) ap_cnt_r[b] <= ap_cnt_r[b] + 1;
      end
      // live count pauses while cke is low, self refresh covers itself
      if (pins_o.cmd == CMD_REF) begin
        ref_cnt_r <= 1;
        live_r <= 1;
        ref_seen_r <= 1'b1;
      end else begin
        if (ref_cnt_r < 100000) ref_cnt_r <= ref_cnt_r + 1;
        if (pins_o.cke && live_r < 100000) live_r <= live_r + 1;
      end
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_trc; act |-> act_cnt_r[pins_o.ba] >= T_RC_CK; endproperty
  a_trc: assert property (p_trc)
    else $error("bank reopened inside row cycle time");
  property p_rd_act; (act && !ap_wr_r[pins_o.ba]) |-> ap_cnt_r[pins_o.ba] >= RD_GAP; endproperty
  a_rd_act: assert property (p_rd_act)
    else $error("activate too soon after read with self precharge");
  property p_wr_act; (act && ap_wr_r[pins_o.ba]) |-> ap_cnt_r[pins_o.ba] >= WR_GAP; endproperty
  a_wr_act: assert property (p_wr_act)
    else $error("activate too soon after write with self precharge");
  property p_trfc;
    ((act || (pins_o.cmd == CMD_REF && pins_o.cke)) && ref_seen_r) |-> ref_cnt_r >= T_RFC_CK;
  endproperty
  a_trfc: assert property (p_trfc)
    else $error("command inside refresh cycle time");
  property p_refi; live_r <= REFI_SPAN * REFI_CK; endproperty
  a_refi: assert property (p_refi)
    else $error("refresh gap too long");
  property p_cke_low; $fell(pins_o.cke) |=> !pins_o.cke [*2]; endproperty
  a_cke_low: assert property (p_cke_low)
    else $error("cke low held too briefly");
  property p_pd_exit; $rose(pins_o.cke) |-> nop ##1 nop; endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("command inside exit latency");
  property p_freq; freq_chg_ok_o |-> !pins_o.cke && !pins_o.odt && !$past(pins_o.cke); endproperty
  a_freq: assert property (p_freq)
    else $error("frequency change allowed too early");
  property p_rdap;
    (req_valid_i && req_ready_o && req_i.kind == REQ_RD_AP) |=> pins_o.cmd == CMD_RD && pins_o.a[A10_BIT];
  endproperty
  a_rdap: assert property (p_rdap)
    else $error("read request without a10 high");
endmodule
`default_nettype wire

// ---- dapr_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// behavioural memory device; counts bank faults, refresh with a busy bank, self refresh entry with odt on, and non-nop power-down exits
module dapr_mem_model
  import dapr_pkg::*;
#(
  parameter int BL = 4,
  parameter int AL = 0
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire dapr_pins_t pins_i,
  output logic [7:0] bad_o,
  output logic sr_o,
  output logic [15:0] refs_o
);
  localparam int T8 = (BL == 8) ? 2 : 0;
  int cyc, pre, sr_at;
  int act_at [BANKS];
  int idle_at [BANKS];
  logic [BANKS-1:0] open_r;
  logic [1:0] b, ref_bank_r;
  logic dll_on_r, cke_q;
  function automatic int mx(input int x, input int y);
    return (x > y) ? x : y;
  endfunction
  // fault and refresh counts survive a reset on purpose
  initial begin
    bad_o = 8'h00;
    refs_o = 16'h0000;
    cyc = 0;
    ref_bank_r = 2'h0;
  end
  // one command decoded per rising edge
  always @(posedge clk_sys_i) begin
    cyc++;
    b = pins_i.ba;
    if (!rstn_i) begin
      open_r = '0;
      sr_o = 1'b0;
      dll_on_r = 1'b1;
      for (int i = 0; i < BANKS; i++) begin
        act_at[i] = -100;
        idle_at[i] = 0;
      end
    end else if (sr_o) begin
      // only cke matters; one refresh inside, loop back on exit
      if (cyc == sr_at + 1) refs_o++;
      if (pins_i.cke) begin
        sr_o = 1'b0;
        dll_on_r = 1'b1;
      end
    end else if (!cke_q) begin
      // leave power-down only with a nop
      if (pins_i.cke && !pins_i.cmd.cs_n && pins_i.cmd != CMD_NOP) bad_o++;
      if (pins_i.cke) dll_on_r = 1'b1;
    end else if (pins_i.cmd == CMD_ACT) begin
      // reopen only after precharge and row cycle
      if (open_r[b] || cyc < idle_at[b] || cyc - act_at[b] < T_RC_CK) bad_o++;
      open_r[b] = 1'b1;
      act_at[b] = cyc;
    end else if (pins_i.cmd == CMD_RD || pins_i.cmd == CMD_WR) begin
      if (!open_r[b]) bad_o++;
      open_r[b] = !pins_i.a[A10_BIT];
      // precharge at al+bl/2, pushed out by tras and trtp
      pre = mx(mx(cyc + AL + BL / 2, act_at[b] + T_RAS_CK), cyc + AL + T8 + T_RTP_CK);
      // write recovery ahead of the precharge
      if (pins_i.cmd == CMD_WR) pre = mx(pre, cyc + AL + BL / 2 + T_WR_CK);
      idle_at[b] = pre + T_RP_CK;
    end else if (pins_i.cmd == CMD_REF) begin
      // every bank idle for trp first
      for (int i = 0; i < BANKS; i++) if (open_r[i] || cyc < idle_at[i]) bad_o++;
      // bank from the internal counter, address pins ignored
      ref_bank_r++;
      if (pins_i.cke) begin
        refs_o++;
      end else begin
        // self refresh entry needs odt off; loop stops
        if (pins_i.odt) bad_o++;
        sr_o = 1'b1;
        dll_on_r = 1'b0;
        sr_at = cyc;
      end
    end else if (!pins_i.cke) begin
      // precharge power-down stops the loop, active keeps it
      dll_on_r = |open_r;
    end
    cke_q = pins_i.cke;
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dapr_pkg::*;
  localparam int REFI = 50;
  localparam int XSRD = 10;
  logic clk_sys_i, rstn_i, req_valid_i, wake_i, clk_stable_i, sr, cke_q;
  logic req_ready_o, clk_stop_ok_o, freq_chg_ok_o, reinit_req_o, busy;
  dapr_user_t req_i;
  dapr_pins_t pins_o;
  logic [7:0] bad;
  logic [15:0] refs;
  int mismatches, comparisons, cyc, t_act, t_rd, t_wr, t_ref, t_mrs, t_rise, t_fall, t0;
  dapr_ctrl #(.REFI_CK(REFI), .XSRD_CK(XSRD)) dapr_ctrl_i (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .wake_i(wake_i), .clk_stable_i(clk_stable_i), .pins_o(pins_o),
    .clk_stop_ok_o(clk_stop_ok_o), .freq_chg_ok_o(freq_chg_ok_o),
    .reinit_req_o(reinit_req_o), .busy_o(busy));
  dapr_mem_model dapr_mem_model_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .pins_i(pins_o),
    .bad_o(bad), .sr_o(sr), .refs_o(refs));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // cycle stamps of what the pins carried, all taken at sampling time
  always @(posedge clk_sys_i) begin
    cyc++;
    if (pins_o.cmd == CMD_ACT) t_act = cyc;
    if (pins_o.cmd == CMD_RD) t_rd = cyc;
    if (pins_o.cmd == CMD_WR) t_wr = cyc;
    if (pins_o.cmd == CMD_MRS) t_mrs = cyc;
    if (pins_o.cmd == CMD_REF && pins_o.cke) t_ref = cyc;
    if (pins_o.cke && !cke_q) t_rise = cyc;
    if (!pins_o.cke && cke_q) t_fall = cyc;
    cke_q = pins_o.cke;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_ge(input string what, input int lo, input int got);
    comparisons++;
    if (got < lo) begin
      mismatches++;
      $display("[FAIL] %s expected >= %0d seen %0d", what, lo, got);
    end
  endtask
  // hold the request until a sampled ready, release after the taking edge
  task automatic req(input dapr_req_t k, input logic [1:0] bk, input logic [12:0] ad);
    @(posedge clk_sys_i);
    req_i <= '{k, bk, ad};
    req_valid_i <= 1'b1;
    @(negedge clk_sys_i);
    for (int n = 0; n < 3000 && req_ready_o !== 1'b1; n++) @(negedge clk_sys_i);
    chk("request taken", 1'b1, req_ready_o);
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic wake_up;
    @(posedge clk_sys_i);
    wake_i <= 1'b1;
    for (int n = 0; n < 500 && pins_o.cke !== 1'b1; n++) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    wake_i <= 1'b0;
  endtask
  task automatic sc_reset;
    rstn_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk("reset pins", {CMD_NOP, 2'b00}, {pins_o.cmd, pins_o.cke, pins_o.odt});
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
  endtask
  localparam int BL_WR_GAP = 4 / 2 + T_WR_CK + T_RP_CK;
  localparam int RD_ACT_GAP = (4 / 2 + T_RP_CK > T_RTPRP_CK) ? 4 / 2 + T_RP_CK : T_RTPRP_CK;
  task automatic sc_autopre;
    req(REQ_ACT, 2'h0, 13'h0123);
    @(negedge clk_sys_i);
    chk("act pins", {CMD_ACT, 2'h0, 1'b1}, {pins_o.cmd, pins_o.ba, pins_o.odt});
    repeat (2) @(negedge clk_sys_i);
    t0 = t_act;
    req(REQ_RD_AP, 2'h0, 13'h0000);
    @(negedge clk_sys_i);
    chk("read pins", {CMD_RD, 1'b1}, {pins_o.cmd, pins_o.a[A10_BIT]});
    req(REQ_ACT, 2'h0, 13'h0000);
    repeat (2) @(negedge clk_sys_i);
    chk_ge("read to act", RD_ACT_GAP, t_act - t_rd);
    chk_ge("act to act", T_RC_CK, t_act - t0);
    req(REQ_ACT, 2'h1, 13'h0000);
    req(REQ_WR_AP, 2'h1, 13'h0000);
    @(negedge clk_sys_i);
    chk("write pins", {CMD_WR, 1'b1}, {pins_o.cmd, pins_o.a[A10_BIT]});
    req(REQ_ACT, 2'h1, 13'h0000);
    repeat (2) @(negedge clk_sys_i);
    chk_ge("write to act", BL_WR_GAP, t_act - t_wr);
    // close both banks, else refresh and self refresh stay refused
    req(REQ_RD_AP, 2'h0, 13'h0000);
    req(REQ_RD_AP, 2'h1, 13'h0000);
  endtask
  task automatic sc_selfref;
    int t_exit;
    req(REQ_SELF_REF, 2'h0, 13'h0000);
    for (int n = 0; n < 300 && sr !== 1'b1; n++) @(negedge clk_sys_i);
    chk("self refresh odt", 2'b10, {sr, pins_o.odt});
    @(posedge clk_sys_i);
    clk_stable_i <= 1'b0;
    wake_i <= 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk("cke while clock unstable", 2'b01, {pins_o.cke, clk_stop_ok_o});
    @(posedge clk_sys_i);
    clk_stable_i <= 1'b1;
    wake_up();
    req(REQ_ACT, 2'h2, 13'h0000);
    req(REQ_RD_AP, 2'h2, 13'h0400);
    repeat (2) @(negedge clk_sys_i);
    t_exit = t_rise;
    chk_ge("exit to act", T_XSNR_CK, t_act - t_exit);
    chk_ge("exit to read", XSRD, t_rd - t_exit);
    req(REQ_SELF_REF, 2'h0, 13'h0000);
    for (int n = 0; n < 300 && sr !== 1'b1; n++) @(negedge clk_sys_i);
    chk_ge("refresh before reentry", 1, t_ref - t_exit);
    wake_up();
  endtask
  task automatic sc_pdown;
    req(REQ_ACT, 2'h3, 13'h0000);
    req(REQ_PDOWN, 2'h3, 13'h0000);
    for (int n = 0; n < 300 && pins_o.cke !== 1'b0; n++) @(negedge clk_sys_i);
    chk("active power-down cke", 2'b01, {pins_o.cke, busy});
    wake_up();
    req(REQ_RD_AP, 2'h3, 13'h0400);
    repeat (2) @(negedge clk_sys_i);
    chk_ge("power-down exit to read", T_XP_CK, t_rd - t_rise);
    req(REQ_FREQ_CHG, 2'h0, 13'h0000);
    for (int n = 0; n < 300 && freq_chg_ok_o !== 1'b1; n++) @(negedge clk_sys_i);
    chk("freq change pins", 3'b100, {freq_chg_ok_o, pins_o.cke, pins_o.odt});
    chk_ge("cke low before freq change", T_FCHG_CK, cyc - t_fall + 1);
    wake_up();
    req(REQ_ACT, 2'h0, 13'h0000);
    chk_ge("loop reset after exit", 1, t_mrs - t_rise + 1);
  endtask
  task automatic sc_refresh_abort;
    req(REQ_RD_AP, 2'h0, 13'h0000);
    repeat (3 * REFI) @(negedge clk_sys_i);
    chk_ge("refresh slack", 0, REFI_SPAN * REFI - (cyc - t_ref));
    chk("device faults", 8'h00, bad);
    req(REQ_ABORT, 2'h0, 13'h0000);
    for (int n = 0; n < 100 && reinit_req_o !== 1'b1; n++) @(negedge clk_sys_i);
    chk("abort reinit", 2'b10, {reinit_req_o, pins_o.cke});
    sc_reset();
    @(negedge clk_sys_i);
    chk("reinit after reset", 1'b0, reinit_req_o);
  endtask
  task automatic final_report;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rstn_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    wake_i = 1'b0;
    clk_stable_i = 1'b1;
    sc_reset();
    sc_autopre();
    sc_selfref();
    sc_pdown();
    sc_refresh_abort();
    final_report();
  end
  // hang guard well beyond the expected few hundred cycles
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    mismatches++;
    final_report();
  end
endmodule
bind dapr_ctrl dapr_monitor #(.BL(BL), .AL(AL), .REFI_CK(REFI_CK), .XSRD_CK(XSRD_CK))
  dapr_monitor_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .pins_o(pins_o),
  .freq_chg_ok_o(freq_chg_ok_o));
`default_nettype wire
